// ### dv/conv_timing_sva.sv
// Port assertions for the conversion timer.
`timescale 1ns/1ps
module conv_timing_sva #(
   parameter SCALE_NUM = 32'd1,
   parameter SCALE_DEN = 32'd1
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire mod_clk_en,
   input wire amp_enable,
   input wire [2:0] eff_gain,
   input wire result_ready_n,
   input wire irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
   a_modclk_gap: assert property (mod_clk_en |=> !mod_clk_en [*7])
      else $error("modulator pulses too close");
   a_bypass_clamp: assert property (!amp_enable |-> eff_gain <= 3'h2)
      else $error("gain above four while bypassed");
   a_reset_idle: assert property ($rose(aresetn) |-> result_ready_n && !irq)
      else $error("outputs busy after reset");
endmodule // conv_timing_sva
bind conv_timing conv_timing_sva #(.SCALE_NUM(SCALE_NUM), .SCALE_DEN(SCALE_DEN)) u_sva (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .mod_clk_en, .amp_enable, .eff_gain, .result_ready_n, .irq
);

// ### dv/sample_src.sv
// Sample source model that feeds a fresh value after every finished conversion.
`timescale 1ns/1ps
module sample_src (
   input wire aclk,
   input wire aresetn,
   input wire result_ready_n,
   output reg [15:0] sample_in
);
   reg prev_r;
   always @(posedge aclk) begin
      prev_r <= result_ready_n;
      if (!aresetn) begin
         sample_in <= 16'h1234;
      end else if (prev_r && !result_ready_n) begin
         sample_in <= sample_in + 16'h0101;
      end
   end
endmodule // sample_src

// ### dv/tb.sv
// Self-checking bench for the conversion timer.
`timescale 1ns/1ps
module tb;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h00000000;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire mod_clk_en, amp_enable, result_ready_n, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] sample_in;
   wire [2:0] eff_gain;
   integer errors = 0, check_count = 0, cycles = 0;
   always #10 aclk = ~aclk;
   sample_src i_src (.aclk, .aresetn, .result_ready_n, .sample_in);
   // Conversion and start-latency counts are shortened a hundredfold so the whole run stays small.
   conv_timing #(.SCALE_NUM(32'd1), .SCALE_DEN(32'd100)) i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_in, .mod_clk_en,
      .amp_enable, .eff_gain, .result_ready_n, .irq
   );
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", check_count, errors);
         if (errors == 0 && check_count > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 60000) begin
         errors = errors + 1;
         close_out;
      end
   end
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
         s_axi_bready <= 1'b1;
         do @(posedge aclk); while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do @(posedge aclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         s_axi_rready <= 1'b1;
         do @(posedge aclk); while (!s_axi_rvalid);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task wfall(output integer n);
      begin
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
         end while (result_ready_n !== 1'b0);
      end
   endtask
   task gap(output integer n);
      begin
         n = 0;
         do @(posedge aclk); while (mod_clk_en !== 1'b1);
         do begin
            @(posedge aclk);
            n = n + 1;
         end while (mod_clk_en !== 1'b1);
      end
   endtask
   initial begin : main
      integer i, n;
      integer tm [0:5];
      reg [31:0] d, cf;
      reg [1:0] r;
      reg [3:0] sel;
      reg [2:0] g, eg;
      reg byp;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 32; i = i + 1) begin
         sel = i[4] ? (i[3] ? 4'hB : 4'h8) : (i[3] ? 4'hC : 4'h7);
         g = (i[2:1] == 2'h3) ? 3'h7 : {1'b0, i[2:1]} + 3'h1;
         byp = (sel[3:2] == 2'h2) || (i[0] && g <= 3'h2);
         eg = (sel[3:2] == 2'h2 && g > 3'h2) ? 3'h2 : g;
         wr(8'h04, {24'h000000, i[0], g, sel});
         chk("amp", amp_enable, !byp);
         chk("gain", eff_gain, eg);
         rd(8'h18, d, r);
         chk("effect", d, {28'h0000000, !byp, eg});
      end
      wr(8'h04, 32'h00006000);
      rd(8'h18, d, r);
      chk("line on", d, 32'h00000038);
      wr(8'h04, 32'h00006400);
      rd(8'h18, d, r);
      chk("line off", d, 32'h00000008);
      $display("bypass test done");
      wr(8'h10, 32'h00000001);
      for (i = 0; i < 3; i = i + 1) begin
         wr(8'h04, 32'h00009800 | (i << 8));
         wr(8'h00, 32'h00000001);
         wfall(tm[i]);
         cf = {16'h0000, sample_in};
         @(posedge aclk);
         chk("irq set", irq, 1'h1);
         rd(8'h14, d, r);
         chk("result", d, cf);
         @(posedge aclk);
         chk("ready up", result_ready_n, 1'h1);
         rd(8'h0C, d, r);
         chk("done", d[0], 1'h1);
         @(posedge aclk);
         chk("irq clear", irq, 1'h0);
         // Expected counts are the table figures divided by the bench scale of 100.
         wfall(n);
         rd(8'h20, d, r);
         chk("period", d, (i == 2) ? 32'h14 : ((i == 1) ? 32'hA6 : 32'h29));
         gap(n);
         chk("modclk", n, (i == 2) ? 32'h8 : 32'h10);
         wr(8'h00, 32'h00000002);
      end
      chk("latency", tm[2], 32'h15);
      chk("latency n", tm[0], 32'h2B);
      chk("latency d", tm[1], 32'hA8);
      $display("continuous test done");
      wr(8'h10, 32'h00000000);
      for (i = 0; i < 6; i = i + 1) begin
         case (i)
            0: cf = 32'h00001800;
            1: cf = 32'h00001900;
            2: cf = 32'h00011800;
            3: cf = 32'h00001A00;
            4: cf = 32'h00011800;
            default: cf = 32'h00031800;
         endcase
         wr(8'h04, cf);
         if (i > 3) wr(8'h00, 32'h00000004);
         wr(8'h00, 32'h00000001);
         wfall(tm[i]);
      end
      chk("duty", tm[1], tm[0]);
      chk("single", tm[0], 32'h2A);
      chk("osc", tm[2], 32'h9EE);
      chk("turbo", tm[3], 32'h15);
      chk("warm", tm[4], 32'h2B);
      chk("fast", tm[5], 32'h9EE);
      chk("masked", irq, 1'h0);
      rd(8'h0C, d, r);
      chk("done", d[0], 1'h1);
      $display("single-shot test done");
      rd(8'h24, d, r);
      chk("resp", r, 2'h2);
      chk("data", d, 32'h00000000);
      $display("unmapped test done");
      close_out;
   end
endmodule // tb

// ### verilog/conv_timing.v
// Conversion sequencer with amplifier control, modulator divider and AXI4-Lite registers.
//
// What this block does
// - Amplifier skip only honored for gain 1, 2, 4.
// - Selections 1000-1011 force amplifier bypass.
// - Forced bypass clamps gain above 4 to 4.
// - Modulator clock: divide 16 normal/duty, 8 turbo.
// - Filter settles in one conversion cycle.
// - Line rejection only at rate index 0: 5/20 SPS, and 40 SPS in turbo.
// - Rates scale with clock versus 4.096 MHz.
// - Continuous period between result-ready falling edges.
// - First conversion after 210 or 114 clocks.
// - Single-shot time ends at result-ready fall.
// - Internal oscillator adds wake delay single-shot.
// - Oscillator powers up at first SCLK rise.
// - Fast SCLK: hold conversion until oscillator runs.
// - Duty single-shot equals normal single-shot times.
// - Normal mode uses tabulated counts 20-1000 SPS.
// - Duty mode continuous counts 823120 to 16656.
// - Turbo mode uses tabulated counts 40-2000 SPS.
`timescale 1ns/1ps
`include "conv_timing_defines.vh"
module conv_timing #(
   parameter SCALE_NUM = 32'd1,
   parameter SCALE_DEN = 32'd1
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [15:0] sample_in,
   output reg mod_clk_en,
   output reg amp_enable,
   output reg [2:0] eff_gain,
   output reg result_ready_n,
   output wire irq
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAKE = 2'd1;
   localparam ST_LAT = 2'd2;
   localparam ST_CONV = 2'd3;
   localparam [31:0] WAKE_N = `WAKE_NORMAL_US * `CLK_MHZ;
   localparam [31:0] WAKE_T = `WAKE_TURBO_US * `CLK_MHZ;

   reg [31:0] cfg_r;
   reg [1:0] irq_stat_r;
   reg [1:0] irq_mask_r;
   reg [15:0] result_r;
   reg [1:0] state_r;
   reg [31:0] cnt_r;
   reg [4:0] div_r;
   reg first_r;
   reg osc_up_r;
   reg aw_got_r, w_got_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg done_r;
   reg [31:0] since_r;
   reg [31:0] period_r;

   wire [3:0] sel = cfg_r[`CFG_SEL_LSB+3:`CFG_SEL_LSB];
   wire [2:0] gain = cfg_r[`CFG_GAIN_LSB+2:`CFG_GAIN_LSB];
   wire skip = cfg_r[`CFG_SKIP_BIT];
   wire [1:0] mode = cfg_r[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
   wire [2:0] rate = cfg_r[`CFG_RATE_LSB+2:`CFG_RATE_LSB];
   wire cont = cfg_r[`CFG_CONT_BIT];
   wire turbo = (mode == `MODE_TURBO);
   // The line-reject choice only takes effect at the slowest rate index.
   wire [1:0] line_eff = (rate == 3'd0) ?
                         cfg_r[`CFG_LINE_LSB+1:`CFG_LINE_LSB] : 2'b00;

   // Tabulated conversion counts at the 4.096 MHz reference clock.
   function [31:0] conv_count;
      input [1:0] md;
      input [2:0] rt;
      input single;
      begin
         conv_count = 32'd0;
         if (md == `MODE_TURBO) begin
            case (rt)
               3'd0: conv_count = single ? 32'd102434 : 32'd102384;
               3'd1: conv_count = single ? 32'd45618 : 32'd45560;
               3'd2: conv_count = single ? 32'd23122 : 32'd23064;
               3'd3: conv_count = single ? 32'd11890 : 32'd11832;
               3'd4: conv_count = single ? 32'd6290 : 32'd6232;
               3'd5: conv_count = single ? 32'd3506 : 32'd3448;
               default: conv_count = single ? 32'd2130 : 32'd2072;
            endcase
         end else if (md == `MODE_DUTY && !single) begin
            case (rt)
               3'd0: conv_count = 32'd823120;
               3'd1: conv_count = 32'd364560;
               3'd2: conv_count = 32'd184592;
               3'd3: conv_count = 32'd94736;
               3'd4: conv_count = 32'd49936;
               3'd5: conv_count = 32'd27664;
               default: conv_count = 32'd16656;
            endcase
         end else begin
            case (rt)
               3'd0: conv_count = single ? 32'd204850 : 32'd204768;
               3'd1: conv_count = single ? 32'd91218 : 32'd91120;
               3'd2: conv_count = single ? 32'd46226 : 32'd46128;
               3'd3: conv_count = single ? 32'd23762 : 32'd23664;
               3'd4: conv_count = single ? 32'd12562 : 32'd12464;
               3'd5: conv_count = single ? 32'd6994 : 32'd6896;
               default: conv_count = single ? 32'd4242 : 32'd4144;
            endcase
         end
      end
   endfunction

   // Counts are in system clock periods, so rates track the clock; the scale
   // lets the integrator retarget the reference without changing the table.
   function [31:0] scaled;
      input [31:0] n;
      reg [63:0] p;
      begin
         p = {32'd0, n} * {32'd0, SCALE_NUM};
         scaled = p[31:0] / SCALE_DEN;
      end
   endfunction

   // Amplifier path and effective gain code.
   always @* begin
      amp_enable = 1'b1;
      eff_gain = gain;
      if (sel[3:2] == 2'b10) begin
         amp_enable = 1'b0;
         if (gain > 3'd2)
            eff_gain = 3'd2;
      end else if (skip && gain <= 3'd2) begin
         amp_enable = 1'b0;
      end
   end

   // Modulator clock enable.
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 5'd0;
         mod_clk_en <= 1'b0;
      end else begin
         if (div_r >= (turbo ? `DIV_TURBO : `DIV_NORMAL) - 5'd1) begin
            div_r <= 5'd0;
            mod_clk_en <= 1'b1;
         end else begin
            div_r <= div_r + 5'd1;
            mod_clk_en <= 1'b0;
         end
      end
   end

   // AXI write channel.
   wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready = !w_got_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   // Every command bit of a control write is decoded the same way, from byte lane 0.
   function ctrl_cmd;
      input fire;
      input [7:0] addr;
      input [3:0] strb;
      input [31:0] data;
      input integer pos;
      begin
         ctrl_cmd = fire && (addr == `REG_CTRL) && strb[0] && data[pos];
      end
   endfunction
   wire start_cmd = ctrl_cmd(wr_fire, awaddr_r, wstrb_r, wdata_r, `CTRL_START_BIT);
   wire stop_cmd = ctrl_cmd(wr_fire, awaddr_r, wstrb_r, wdata_r, `CTRL_STOP_BIT);
   wire sclk_first = ctrl_cmd(wr_fire, awaddr_r, wstrb_r, wdata_r, `CTRL_SCLK_FIRST_BIT);
   wire stat_rd = rd_fire && s_axi_araddr == `REG_IRQ_STAT;
   integer i;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         cfg_r <= `CFG_RESET;
         irq_mask_r <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (awaddr_r)
               `REG_CTRL: ;
               `REG_CFG: begin
                  for (i = 0; i < 4; i = i + 1)
                     if (wstrb_r[i])
                        cfg_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
               end
               `REG_IRQ_MASK: begin
                  if (wstrb_r[0])
                     irq_mask_r <= wdata_r[1:0];
               end
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read channel.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            `REG_CTRL: s_axi_rdata <= 32'h00000000;
            `REG_CFG: s_axi_rdata <= cfg_r;
            `REG_STATUS: s_axi_rdata <= {27'd0, osc_up_r, state_r, first_r, result_ready_n};
            `REG_IRQ_STAT: s_axi_rdata <= {30'd0, irq_stat_r};
            `REG_IRQ_MASK: s_axi_rdata <= {30'd0, irq_mask_r};
            `REG_RESULT: s_axi_rdata <= {16'd0, result_r};
            `REG_EFFECT: s_axi_rdata <= {26'd0, line_eff, amp_enable, eff_gain};
            `REG_COUNT: s_axi_rdata <= cnt_r;
            `REG_PERIOD: s_axi_rdata <= period_r;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Conversion sequencer.
   wire use_osc = cfg_r[`CFG_INTOSC_BIT] && !cont;
   wire fast_sclk = cfg_r[`CFG_FASTSCLK_BIT];
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
         cnt_r <= 32'd0;
         first_r <= 1'b0;
         osc_up_r <= 1'b0;
         result_r <= 16'h0000;
         result_ready_n <= 1'b1;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         // Reading the result releases the line, but a result landing on the same edge
         // must still pull it low, so every later assignment below overrides this one.
         if (rd_fire && s_axi_araddr == `REG_RESULT)
            result_ready_n <= 1'b1;
         if (sclk_first && use_osc)
            osc_up_r <= 1'b1;
         if (stop_cmd) begin
            state_r <= ST_IDLE;
            result_ready_n <= 1'b1;
         end else if (start_cmd) begin
            result_ready_n <= 1'b1;
            first_r <= 1'b1;
            if (use_osc) begin
               // Fast clocks leave the oscillator cold, so the full wake time runs.
               state_r <= ST_WAKE;
               cnt_r <= (fast_sclk || !osc_up_r) ? (turbo ? WAKE_T : WAKE_N) : 32'd1;
            end else if (cont) begin
               state_r <= ST_LAT;
               cnt_r <= scaled(turbo ? `START_LAT_TURBO : `START_LAT_NORMAL);
            end else begin
               state_r <= ST_CONV;
               cnt_r <= scaled(conv_count(mode, rate, 1'b1));
            end
         end else begin
            case (state_r)
               ST_IDLE: ;
               ST_WAKE: begin
                  if (cnt_r <= 32'd1) begin
                     state_r <= ST_CONV;
                     cnt_r <= scaled(conv_count(mode, rate, 1'b1));
                  end else
                     cnt_r <= cnt_r - 32'd1;
               end
               ST_LAT: begin
                  if (cnt_r <= 32'd1) begin
                     state_r <= ST_CONV;
                     cnt_r <= scaled(conv_count(mode, rate, 1'b0));
                  end else
                     cnt_r <= cnt_r - 32'd1;
               end
               ST_CONV: begin
                  if (cnt_r <= 32'd1) begin
                     // One full period per result: the filter has settled by now.
                     result_r <= sample_in;
                     result_ready_n <= 1'b0;
                     done_r <= 1'b1;
                     first_r <= 1'b0;
                     if (cont)
                        cnt_r <= scaled(conv_count(mode, rate, 1'b0));
                     else begin
                        state_r <= ST_IDLE;
                        osc_up_r <= 1'b0;
                     end
                  end else begin
                     cnt_r <= cnt_r - 32'd1;
                     if (cnt_r == 32'd2)
                        result_ready_n <= 1'b1;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Sticky events: bit0 result done, bit1 stop; a read clears, a new event wins.
   always @(posedge aclk) begin
      if (!aresetn)
         irq_stat_r <= 2'b00;
      else
         irq_stat_r <= (stat_rd ? 2'b00 : irq_stat_r) | {stop_cmd, done_r};
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   // Clocks between consecutive result-ready falls. A start or stop restarts the count,
   // so the first figure after a start also holds the start latency.
   always @(posedge aclk) begin
      if (!aresetn) begin
         since_r <= 32'h00000000;
         period_r <= 32'h00000000;
      end else if (start_cmd || stop_cmd) begin
         since_r <= 32'h00000000;
      end else if (done_r) begin
         since_r <= 32'h00000001;
         period_r <= since_r;
      end else begin
         since_r <= since_r + 32'h00000001;
      end
   end
endmodule // conv_timing

// ### verilog/conv_timing_defines.vh
// Register map, field positions, reset values and timing counts of the conversion timer.
`ifndef CONV_TIMING_DEFINES_VH
`define CONV_TIMING_DEFINES_VH
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_RESULT 8'h14
`define REG_EFFECT 8'h18
`define REG_COUNT 8'h1C
`define REG_PERIOD 8'h20
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_SCLK_FIRST_BIT 2
`define CFG_SEL_LSB 0
`define CFG_GAIN_LSB 4
`define CFG_SKIP_BIT 7
`define CFG_MODE_LSB 8
`define CFG_RATE_LSB 10
`define CFG_LINE_LSB 13
`define CFG_CONT_BIT 15
`define CFG_INTOSC_BIT 16
`define CFG_FASTSCLK_BIT 17
`define CFG_RESET 32'h00000000
`define MODE_NORMAL 2'h0
`define MODE_DUTY 2'h1
`define MODE_TURBO 2'h2
`define DIV_NORMAL 5'h10
`define DIV_TURBO 5'h08
`define START_LAT_NORMAL 210
`define START_LAT_TURBO 114
`define WAKE_NORMAL_US 50
`define WAKE_TURBO_US 25
`define CLK_MHZ 50
`define REF_CLK_KHZ 4096
`define FAST_SCLK_NORMAL_KHZ 160
`define FAST_SCLK_TURBO_KHZ 320
`endif
